// file: common/ofl_params.svh
// Constants for the output fault limit and response block.
// Assumes inclusion by ofl_pkg and the design modules only.
`ifndef OFL_PARAMS_SVH
`define OFL_PARAMS_SVH

// Command codes
`define OFL_CMD_CLEAR_FAULTS  8'h03
`define OFL_CMD_GAIN          8'h38
`define OFL_CMD_OFFSET        8'h39
`define OFL_CMD_OV_THRESHOLD  8'h40
`define OFL_CMD_OV_ACTION     8'h41
`define OFL_CMD_UV_THRESHOLD  8'h44
`define OFL_CMD_UV_ACTION     8'h45

// Reset values
`define OFL_GAIN_RESET        16'hBA2A
`define OFL_OFFSET_RESET      16'hBE00
`define OFL_ACTION_RESET      8'h80

// Default thresholds as percent of the strapped output voltage
`define OFL_OV_DEFAULT_PCT    32'd115
`define OFL_UV_DEFAULT_PCT    32'd85
`define OFL_PCT_DIVISOR       32'd100
// Threshold words carry a fixed exponent of -13
`define OFL_VOLT_EXPONENT     -13

// Action byte field positions
`define OFL_MODE_MSB          7
`define OFL_MODE_LSB          6
`define OFL_RETRY_MSB         5
`define OFL_RETRY_LSB         3
`define OFL_TIME_MSB          2
`define OFL_TIME_LSB          0

// Mode and retry encodings
`define OFL_MODE_CONTINUE     2'h0
`define OFL_MODE_DELAY        2'h1
`define OFL_MODE_DISABLE      2'h2
`define OFL_MODE_HOLD         2'h3
`define OFL_RETRY_NONE        3'h0
`define OFL_RETRY_FOREVER     3'h7

// Time unit of the 3-bit time count, per fault type, and clock rate
`define OFL_CLK_MHZ           20
`define OFL_OV_UNIT_US        1000
`define OFL_UV_UNIT_US        1000
`define OFL_OV_UNIT_CYCLES    (`OFL_OV_UNIT_US * `OFL_CLK_MHZ)
`define OFL_UV_UNIT_CYCLES    (`OFL_UV_UNIT_US * `OFL_CLK_MHZ)

// Cycles given to the pin synchroniser before straps are taken
// Three sync stages plus its output flop; fewer loads zero thresholds
`define OFL_STRAP_SETTLE      3'h4

`endif

// file: common/ofl_pkg.sv
// Types for the output fault limit and response block.
// Assumes ofl_params.svh is on the include path.
`include "ofl_params.svh"

package ofl_pkg;

  typedef enum logic [2:0] {
    OFL_OFF,
    OFL_RUN,
    OFL_DELAY,
    OFL_RETRY_WAIT,
    OFL_LATCHED,
    OFL_HOLD
  } ofl_state_type;

  typedef struct packed {
    ofl_state_type state;
    logic [15:0]   gain;
    logic [15:0]   offset;
    logic [15:0]   ov_threshold;
    logic [15:0]   uv_threshold;
    logic [7:0]    ov_action;
    logic [7:0]    uv_action;
    logic          ov_flag;
    logic          uv_flag;
    logic          ov_cond;
    logic          uv_cond;
    logic [7:0]    act;
    logic          act_is_ov;
    logic [2:0]    tries;
    logic [2:0]    units;
    logic [15:0]   cycles;
    logic [15:0]   rdata;
    logic [2:0]    settle;
    logic          strap_done;
    logic          en_prev;
  } ofl_regs_type;

endpackage : ofl_pkg

// file: verilog/ofl_pin_sync.sv
// Three-stage synchroniser for a group of pin inputs.
// Assumes inputs are asynchronous to clk; output moves only when
// the second and third stages agree.
`timescale 1ns/1ns
`default_nettype none

module ofl_pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } ofl_sync_state_type;

  ofl_sync_state_type st_reg;
  ofl_sync_state_type st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = pin_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < WIDTH; i++) begin
      // First stage feeds only the second, never the comparison
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.q[i] = st_reg.s3[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign pin_out = st_reg.q;

endmodule : ofl_pin_sync

`default_nettype wire

// file: verilog/ofl_fault_ctrl.sv
// Output voltage fault supervision with calibration and limit commands.
// Assumes a decoded command port from the bus controller, output voltage
// samples in the threshold format, and a ramp flag from the controller.
//
// Functional notes
// [R1] Gain word, read/write 16 bits, resets to BA2Ah.
// [R2] Current offset word, read/write 16 bits, resets to BE00h.
// [R3] Over-voltage threshold defaults to 1.15 times strapped voltage.
// [R4] Over-voltage faults are never ignored, even with continue mode.
// [R5] Both action bytes read/write and reset to 80h.
// [R6] Mode 00 continue, 01 delay then disable, 10 disable now.
// [R7] Mode 11 keeps output off only while the fault persists.
// [R8] Detected faults set sticky flags until clear-faults.
// [R9] Retry field 000 means no restart after shutdown.
// [R10] Retry 001 to 110 gives that many restarts, spaced by time count.
// [R11] Retry 111 restarts forever until disabled or other shutdown.
// [R12] Time count sets retry spacing and reaction delay, unit per fault.
// [R13] Under-voltage detection masked while ramping or disabled.
// [R14] Under-voltage threshold defaults to 0.85 times strapped voltage.
// [R15] Clear-faults clears flags, no restart, live faults set again.
// [R16] Threshold words are mantissas with exponent minus thirteen.
// [R17] Sample above OV threshold or below unmasked UV threshold faults.
// [R18] Retry allowance reloads whenever the output is re-enabled.
`timescale 1ns/1ns
`default_nettype none
`include "ofl_params.svh"

module ofl_fault_ctrl #(
  parameter int OV_UNIT_CYCLES = `OFL_OV_UNIT_CYCLES,
  parameter int UV_UNIT_CYCLES = `OFL_UV_UNIT_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        ce,
  input  wire logic        enable_pin,
  input  wire logic [15:0] strap_vout_pin,
  input  wire logic        run_cmd,
  input  wire logic        ramping,
  input  wire logic        sample_valid,
  input  wire logic [15:0] vout_sample,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] cmd_wdata,
  output logic             cmd_ack,
  output logic             cmd_unsupported,
  output logic [15:0]      cmd_rdata,
  output logic             output_on,
  output logic             ov_fault,
  output logic             uv_fault,
  output logic [15:0]      current_sense_gain,
  output logic [15:0]      current_sense_offset
);

  localparam logic [15:0] OV_UNIT = 16'(OV_UNIT_CYCLES - 1);
  localparam logic [15:0] UV_UNIT = 16'(UV_UNIT_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////
  // Pin inputs

  logic        enable_sync;
  logic [15:0] strap_sync;

  ofl_pin_sync #(
    .WIDTH (17)
  ) u_pin_sync (
    .clk     (clk),
    .srst    (srst),
    .ce      (ce),
    .pin_in  ({enable_pin, strap_vout_pin}),
    .pin_out ({enable_sync, strap_sync})
  );

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic is_known(input logic [7:0] code);
    case (code)
      `OFL_CMD_CLEAR_FAULTS,
      `OFL_CMD_GAIN,
      `OFL_CMD_OFFSET,
      `OFL_CMD_OV_THRESHOLD,
      `OFL_CMD_OV_ACTION,
      `OFL_CMD_UV_THRESHOLD,
      `OFL_CMD_UV_ACTION: is_known = 1'b1;
      default:            is_known = 1'b0;
    endcase
  endfunction : is_known

  // Both sides share the exponent, so a plain compare suffices
  function automatic logic [15:0] scale_pct(input logic [15:0] v,
                                            input logic [31:0] pct);
    logic [31:0] prod;
    prod      = 32'(v) * pct; // R16
    scale_pct = 16'(prod / `OFL_PCT_DIVISOR);
  endfunction : scale_pct

  function automatic logic [1:0] mode_of(input logic [7:0] a,
                                         input logic       is_ov);
    logic [1:0] m;
    m = a[`OFL_MODE_MSB:`OFL_MODE_LSB];
    // Continue would leave an over-voltage unprotected
    if (is_ov && m == `OFL_MODE_CONTINUE) begin
      m = `OFL_MODE_DISABLE; // R4
    end
    mode_of = m;
  endfunction : mode_of

  ////////////////////////////////////////////////////////////////////////
  // State

  ofl_pkg::ofl_regs_type r_reg;
  ofl_pkg::ofl_regs_type r_next;

  logic       enabled;
  logic       enable_rise;
  logic       ov_hit;
  logic       uv_hit;
  logic       uv_live;
  logic       clear_cmd;
  logic       wr;
  logic [1:0] act_mode;
  logic [2:0] act_retry;
  logic [2:0] act_time;
  logic [15:0] unit_last;
  logic       timer_done;

  always_comb begin
    enabled     = enable_sync & run_cmd;
    enable_rise = enabled & ~r_reg.en_prev;
    wr          = cmd_valid & cmd_write;
    clear_cmd   = wr && cmd_code == `OFL_CMD_CLEAR_FAULTS;
    act_mode    = mode_of(r_reg.act, r_reg.act_is_ov);
    act_retry   = r_reg.act[`OFL_RETRY_MSB:`OFL_RETRY_LSB];
    act_time    = r_reg.act[`OFL_TIME_MSB:`OFL_TIME_LSB];
    unit_last   = r_reg.act_is_ov ? OV_UNIT : UV_UNIT; // R12
    timer_done  = r_reg.units == 3'h0 && r_reg.cycles == 16'h0000;
    ov_hit      = sample_valid && r_reg.strap_done
                  && vout_sample > r_reg.ov_threshold; // R17
    // Masked while ramping and whenever the output is off
    uv_live     = r_reg.state == ofl_pkg::OFL_RUN && !ramping; // R13
    uv_hit      = sample_valid && uv_live && r_reg.strap_done
                  && vout_sample < r_reg.uv_threshold; // R17
  end

  always_comb begin
    r_next         = r_reg;
    r_next.en_prev = enabled;
    r_next.rdata   = 16'h0000;

    // Strap capture once the synchroniser has settled
    if (!r_reg.strap_done) begin
      if (r_reg.settle == `OFL_STRAP_SETTLE) begin
        r_next.strap_done   = 1'b1;
        r_next.ov_threshold = scale_pct(strap_sync,
                                        `OFL_OV_DEFAULT_PCT); // R3
        r_next.uv_threshold = scale_pct(strap_sync,
                                        `OFL_UV_DEFAULT_PCT); // R14
      end else begin
        r_next.settle = r_reg.settle + 3'h1;
      end
    end

    // Command port
    if (cmd_valid) begin
      case (cmd_code)
        `OFL_CMD_GAIN: begin
          r_next.rdata = r_reg.gain;
          if (cmd_write) r_next.gain = cmd_wdata; // R1
        end
        `OFL_CMD_OFFSET: begin
          r_next.rdata = r_reg.offset;
          if (cmd_write) r_next.offset = cmd_wdata; // R2
        end
        `OFL_CMD_OV_THRESHOLD: begin
          r_next.rdata = r_reg.ov_threshold;
          if (cmd_write) r_next.ov_threshold = cmd_wdata; // R3
        end
        `OFL_CMD_UV_THRESHOLD: begin
          r_next.rdata = r_reg.uv_threshold;
          if (cmd_write) r_next.uv_threshold = cmd_wdata; // R14
        end
        `OFL_CMD_OV_ACTION: begin
          r_next.rdata = {8'h00, r_reg.ov_action};
          if (cmd_write) r_next.ov_action = cmd_wdata[7:0]; // R5
        end
        `OFL_CMD_UV_ACTION: begin
          r_next.rdata = {8'h00, r_reg.uv_action};
          if (cmd_write) r_next.uv_action = cmd_wdata[7:0]; // R5
        end
        default: r_next.rdata = 16'h0000;
      endcase
    end

    // Live conditions follow each sample; a masked UV reads as gone
    if (sample_valid) begin
      r_next.ov_cond = ov_hit;
      r_next.uv_cond = uv_hit;
    end else if (!uv_live) begin
      r_next.uv_cond = 1'b0;
    end

    // Set wins over clear; live faults reassert on clear
    r_next.ov_flag = (r_reg.ov_flag & ~clear_cmd) | ov_hit
                     | (clear_cmd & r_reg.ov_cond); // R8 R15
    r_next.uv_flag = (r_reg.uv_flag & ~clear_cmd) | uv_hit
                     | (clear_cmd & r_reg.uv_cond); // R8 R15

    // Timer: units of the time count, each unit_last+1 cycles
    if (!timer_done) begin
      if (r_reg.cycles == 16'h0000) begin
        r_next.units  = r_reg.units - 3'h1;
        r_next.cycles = unit_last;
      end else begin
        r_next.cycles = r_reg.cycles - 16'h0001;
      end
    end

    case (r_reg.state)
      ofl_pkg::OFL_OFF: begin
        if (enable_rise && r_reg.strap_done) begin
          r_next.state = ofl_pkg::OFL_RUN;
        end
      end
      ofl_pkg::OFL_RUN: begin
        if (ov_hit || uv_hit) begin
          r_next.act       = ov_hit ? r_reg.ov_action : r_reg.uv_action;
          r_next.act_is_ov = ov_hit;
          r_next.units     = ov_hit
                             ? r_reg.ov_action[`OFL_TIME_MSB:`OFL_TIME_LSB]
                             : r_reg.uv_action[`OFL_TIME_MSB:`OFL_TIME_LSB];
          r_next.cycles    = ov_hit ? OV_UNIT : UV_UNIT;
          case (mode_of(r_next.act, ov_hit))
            `OFL_MODE_CONTINUE: r_next.state = ofl_pkg::OFL_RUN; // R6
            `OFL_MODE_DELAY:    r_next.state = ofl_pkg::OFL_DELAY; // R6
            `OFL_MODE_DISABLE:  r_next.state = ofl_pkg::OFL_DELAY; // R6
            default:            r_next.state = ofl_pkg::OFL_HOLD; // R7
          endcase
          // Disable-now skips the reaction delay
          if (mode_of(r_next.act, ov_hit) == `OFL_MODE_DISABLE) begin
            r_next.units  = 3'h0;
            r_next.cycles = 16'h0000;
          end
        end
      end
      ofl_pkg::OFL_DELAY: begin
        if (timer_done) begin
          r_next.units  = act_time; // R12
          r_next.cycles = unit_last;
          if (act_retry == `OFL_RETRY_NONE) begin
            r_next.state = ofl_pkg::OFL_LATCHED; // R9
          end else if (act_retry == `OFL_RETRY_FOREVER) begin
            r_next.state = ofl_pkg::OFL_RETRY_WAIT; // R11
          end else if (r_reg.tries != act_retry) begin
            // Attempts used so far, so the striking fault sets the limit
            r_next.tries = r_reg.tries + 3'h1; // R10
            r_next.state = ofl_pkg::OFL_RETRY_WAIT;
          end else begin
            r_next.state = ofl_pkg::OFL_LATCHED; // R10
          end
        end
      end
      ofl_pkg::OFL_RETRY_WAIT: begin
        if (timer_done) begin
          r_next.state = ofl_pkg::OFL_RUN; // R10 R11
        end
      end
      ofl_pkg::OFL_HOLD: begin
        // Off output cannot show a UV, so UV hold ends at once
        if (!r_reg.ov_cond || !r_reg.act_is_ov) begin
          if (!ov_hit) r_next.state = ofl_pkg::OFL_RUN; // R7
        end
      end
      ofl_pkg::OFL_LATCHED: begin
        r_next.state = ofl_pkg::OFL_LATCHED; // R9
      end
      default: r_next.state = ofl_pkg::OFL_OFF;
    endcase

    // Disable wins everywhere; a fresh enable restores the allowance
    if (!enabled) begin
      r_next.state = ofl_pkg::OFL_OFF; // R11
    end
    if (enable_rise) begin
      r_next.tries = 3'h0; // R18
      if (r_next.state == ofl_pkg::OFL_LATCHED) begin
        r_next.state = ofl_pkg::OFL_RUN;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk) begin
    if (srst) begin
      r_reg              <= '0;
      r_reg.state        <= ofl_pkg::OFL_OFF;
      r_reg.gain         <= `OFL_GAIN_RESET; // R1
      r_reg.offset       <= `OFL_OFFSET_RESET; // R2
      r_reg.ov_action    <= `OFL_ACTION_RESET; // R5
      r_reg.uv_action    <= `OFL_ACTION_RESET; // R5
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign cmd_ack              = cmd_valid & is_known(cmd_code);
  assign cmd_unsupported      = cmd_valid & ~is_known(cmd_code);
  assign cmd_rdata            = r_reg.rdata;
  assign output_on            = r_reg.state == ofl_pkg::OFL_RUN
                                || r_reg.state == ofl_pkg::OFL_DELAY;
  assign ov_fault             = r_reg.ov_flag;
  assign uv_fault             = r_reg.uv_flag;
  assign current_sense_gain   = r_reg.gain;
  assign current_sense_offset = r_reg.offset;

endmodule : ofl_fault_ctrl

`default_nettype wire

// file: tb/ofl_fault_ctrl_props.sv
// Concurrent checks on the ports of the fault supervision block.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none

module ofl_fault_ctrl_props #(
  parameter int OV_UNIT_CYCLES = 20000,
  parameter int UV_UNIT_CYCLES = 20000
) (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        ce,
  input wire logic        cmd_valid,
  input wire logic        cmd_write,
  input wire logic [7:0]  cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic        cmd_ack,
  input wire logic        cmd_unsupported,
  input wire logic [15:0] cmd_rdata,
  input wire logic        sample_valid,
  input wire logic        ramping,
  input wire logic        output_on,
  input wire logic        ov_fault,
  input wire logic        uv_fault,
  input wire logic [15:0] current_sense_gain
);
  logic known;
  logic clear_cmd;
  assign known = cmd_code inside {8'h03, 8'h38, 8'h39, 8'h40, 8'h41,
                                  8'h44, 8'h45};
  assign clear_cmd = cmd_valid && cmd_write && cmd_code == 8'h03;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst || !ce);

  ////////////////////////////////////////////////////////////////////////
  a_ack_known:
    assert property (cmd_ack == (cmd_valid && known)
      && cmd_unsupported == (cmd_valid && !known))
    else $error("command acknowledge wrong");
  a_rdata_idle:
    assert property (!$past(cmd_valid) |-> cmd_rdata == 16'h0000)
    else $error("read data not idle");
  a_gain_read:
    assert property (cmd_valid && !cmd_write && cmd_code == 8'h38
      |=> cmd_rdata == $past(current_sense_gain))
    else $error("gain read wrong");
  a_gain_write:
    assert property (cmd_valid && cmd_write && cmd_code == 8'h38
      |=> current_sense_gain == $past(cmd_wdata))
    else $error("gain not written");
  a_gain_hold:
    assert property (!(cmd_valid && cmd_write && cmd_code == 8'h38)
      |=> $stable(current_sense_gain))
    else $error("gain changed unasked");
  a_ov_sticky:
    assert property (ov_fault && !clear_cmd |=> ov_fault)
    else $error("ov flag dropped");
  a_uv_sticky:
    assert property (uv_fault && !clear_cmd |=> uv_fault)
    else $error("uv flag dropped");
  a_ov_cause:
    assert property ($rose(ov_fault)
      |-> $past(sample_valid) || $past(sample_valid, 2))
    else $error("ov flag without sample");
  a_uv_mask:
    assert property ($rose(uv_fault)
      |-> ($past(sample_valid) && !$past(ramping))
        || ($past(sample_valid, 2) && !$past(ramping, 2)))
    else $error("uv flag while masked");

  c_ov_trip: cover property ($rose(ov_fault));
  c_uv_trip: cover property ($rose(uv_fault));
  c_restart: cover property ($fell(output_on) ##[1:20] $rose(output_on));
endmodule : ofl_fault_ctrl_props

bind ofl_fault_ctrl ofl_fault_ctrl_props #(
  .OV_UNIT_CYCLES(OV_UNIT_CYCLES),
  .UV_UNIT_CYCLES(UV_UNIT_CYCLES)
) u_props (.clk, .srst, .ce, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata,
  .cmd_ack, .cmd_unsupported, .cmd_rdata, .sample_valid, .ramping,
  .output_on, .ov_fault, .uv_fault, .current_sense_gain);
`default_nettype wire

// file: tb/ofl_host.sv
// Bus host model: one command per call on the decoded command port.
// Assumes calls start just after a rising edge; lines idle inverted.
`timescale 1ns/1ns
`default_nettype none

module ofl_host (
  input  wire logic        clk,
  input  wire logic        cmd_ack,
  input  wire logic        cmd_unsupported,
  input  wire logic [15:0] cmd_rdata,
  output logic             cmd_valid,
  output logic             cmd_write,
  output logic [7:0]       cmd_code,
  output logic [15:0]      cmd_wdata
);
  logic ack_seen = 1'b0;
  logic unsup_seen = 1'b0;
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code  = 8'hFF;
    cmd_wdata = 16'h0000;
  end

  task automatic xfer(input logic w, input logic [7:0] code,
                      input logic [15:0] d, output logic [15:0] q);
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_code  = code;
    cmd_wdata = d;
    @(posedge clk);
    ack_seen  = cmd_ack;
    unsup_seen = cmd_unsupported;
    #1;
    q         = cmd_rdata;
    cmd_valid = 1'b0;
    // Released code and data lines never show the last value; cmd_write keeps it
    cmd_code  = ~code;
    cmd_wdata = ~d;
  endtask : xfer

  task automatic wr(input logic [7:0] code, input logic [15:0] d);
    logic [15:0] q;
    xfer(1'b1, code, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] code, output logic [15:0] q);
    xfer(1'b0, code, 16'h0000, q);
  endtask : rd
endmodule : ofl_host
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the output fault supervision block.
// Assumes the host model drives commands and the checker is bound.
`timescale 1ns/1ns
`default_nettype none

module tb;
  localparam logic [15:0] STRAP  = 16'h2000;
  localparam logic [15:0] OV_DEF = 16'(32'(STRAP) * 115 / 100);
  localparam logic [15:0] UV_DEF = 16'(32'(STRAP) * 85 / 100);
  localparam logic [7:0]  CODES [6] = '{8'h38, 8'h39, 8'h40, 8'h41,
                                        8'h44, 8'h45};
  localparam logic [15:0] DEFS [6] = '{16'hBA2A, 16'hBE00, OV_DEF,
                                       16'h0080, UV_DEF, 16'h0080};
  localparam logic [15:0] MASK [6] = '{16'hFFFF, 16'hFFFF, 16'hFFFF,
                                       16'h00FF, 16'hFFFF, 16'h00FF};
  logic        clk, srst, ce, enable_pin, run_cmd, ramping, sample_valid;
  logic [15:0] vout_sample;
  logic [15:0] rd_val;
  wire logic        cmd_valid, cmd_write, cmd_ack, cmd_unsupported;
  wire logic [7:0]  cmd_code;
  wire logic [15:0] cmd_wdata, cmd_rdata;
  wire logic [15:0] current_sense_gain, current_sense_offset;
  wire logic        output_on, ov_fault, uv_fault;
  int err_count = 0;
  int samples_checked = 0;

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Short time unit keeps retry and delay counts in reach
  ofl_fault_ctrl #(.OV_UNIT_CYCLES(4), .UV_UNIT_CYCLES(4)) uut (
    .clk, .srst, .ce, .enable_pin, .strap_vout_pin(STRAP), .run_cmd,
    .ramping, .sample_valid, .vout_sample, .cmd_valid, .cmd_write,
    .cmd_code, .cmd_wdata, .cmd_ack, .cmd_unsupported, .cmd_rdata,
    .output_on, .ov_fault, .uv_fault, .current_sense_gain,
    .current_sense_offset);
  ofl_host host (.clk, .cmd_ack, .cmd_unsupported, .cmd_rdata, .cmd_valid,
    .cmd_write, .cmd_code, .cmd_wdata);

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic smp(input logic [15:0] v);
    step(1);
    sample_valid = 1'b1;
    vout_sample  = v;
    step(1);
    sample_valid = 1'b0;
    vout_sample  = ~v;
  endtask : smp

  task automatic wait_on(input logic exp, input int lim);
    for (int i = 0; i < lim && output_on !== exp; i++) step(1);
    chk(16'(output_on), 16'(exp));
  endtask : wait_on

  task automatic restart();
    enable_pin = 1'b0;
    step(6);
    enable_pin = 1'b1;
    wait_on(1'b1, 12);
  endtask : restart

  task automatic trip();
    smp(OV_DEF + 16'h0001);
    smp(STRAP);
    step(1);
  endtask : trip

  task automatic done(input string s);
    $display("%0t test %s done, mismatches %0d", $time, s, err_count);
  endtask : done

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    err_count++;
    tally_and_finish();
  end

  initial begin
    srst = 1'b1; ce = 1'b1; enable_pin = 1'b0; run_cmd = 1'b1;
    ramping = 1'b0; sample_valid = 1'b0; vout_sample = STRAP;
    repeat (16) @(posedge clk);
    #1;
    srst = 1'b0;
    step(12);
    for (int i = 0; i < 6; i++) begin
      host.rd(CODES[i], rd_val);
      chk(rd_val, DEFS[i]);
      host.wr(CODES[i], 16'h5A3C);
      host.rd(CODES[i], rd_val);
      chk(rd_val, 16'h5A3C & MASK[i]);
      host.wr(CODES[i], DEFS[i]);
    end
    host.rd(8'h42, rd_val);
    chk(rd_val, 16'h0000);
    chk(16'(host.ack_seen), 16'h0000);
    chk(16'(host.unsup_seen), 16'h0001);
    chk(current_sense_gain, 16'hBA2A);
    chk(current_sense_offset, 16'hBE00);
    // Frozen clock enable must drop the command
    ce = 1'b0;
    host.wr(8'h38, 16'h1234);
    chk(current_sense_gain, 16'hBA2A);
    ce = 1'b1;
    done("registers");

    restart();
    trip();
    chk(16'(ov_fault), 16'h0001);
    chk(16'(output_on), 16'h0000);
    step(20);
    chk(16'(output_on), 16'h0000);
    host.wr(8'h03, 16'h0000);
    step(2);
    chk(16'(ov_fault), 16'h0000);
    chk(16'(output_on), 16'h0000);
    done("latched");

    host.wr(8'h41, 16'h0000);
    restart();
    trip();
    chk(16'(output_on), 16'h0000);
    done("no ignore");

    host.wr(8'h41, 16'h0042);
    restart();
    trip();
    step(2);
    chk(16'(output_on), 16'h0001);
    step(8);
    chk(16'(output_on), 16'h0000);
    done("delay");

    host.wr(8'h41, 16'h0089);
    host.wr(8'h45, 16'h0089);
    restart();
    trip();
    chk(16'(output_on), 16'h0000);
    wait_on(1'b1, 12);
    trip();
    step(20);
    chk(16'(output_on), 16'h0000);
    restart();
    trip();
    chk(16'(output_on), 16'h0000);
    wait_on(1'b1, 12);
    done("counted retry");

    host.wr(8'h41, 16'h00B9);
    host.wr(8'h45, 16'h00B9);
    restart();
    repeat (3) begin
      trip();
      chk(16'(output_on), 16'h0000);
      wait_on(1'b1, 12);
    end
    done("endless retry");

    host.wr(8'h41, 16'h00C0);
    host.wr(8'h45, 16'h0080);
    restart();
    smp(OV_DEF + 16'h0001);
    step(2);
    chk(16'(output_on), 16'h0000);
    host.wr(8'h03, 16'h0000);
    step(2);
    chk(16'(ov_fault), 16'h0001);
    smp(STRAP);
    wait_on(1'b1, 6);
    host.wr(8'h03, 16'h0000);
    step(2);
    chk(16'(ov_fault), 16'h0000);
    done("hold");

    ramping = 1'b1;
    smp(UV_DEF - 16'h0001);
    step(3);
    chk(16'(uv_fault), 16'h0000);
    chk(16'(output_on), 16'h0001);
    ramping = 1'b0;
    host.wr(8'h45, 16'h0000);
    smp(UV_DEF - 16'h0001);
    step(3);
    chk(16'(uv_fault), 16'h0001);
    chk(16'(output_on), 16'h0001);
    smp(STRAP);
    host.wr(8'h03, 16'h0000);
    step(2);
    chk(16'(uv_fault), 16'h0000);
    host.wr(8'h45, 16'h0080);
    smp(UV_DEF - 16'h0001);
    step(3);
    chk(16'(uv_fault), 16'h0001);
    chk(16'(output_on), 16'h0000);
    done("undervoltage");
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
